// file: common/hpsl_pkg.sv
package hpsl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int READY_TIME_NS = 5000;
  // Least time, so round up to whole cycles
  localparam int READY_CYCLES =
    (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles until the pin synchronisers hold settled strap levels
  localparam int SYNC_FILL = 4;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Pin layout of the upper data byte in 8-bit mode
  // ----------------------------------------------------------------
  localparam int HI_WAKE_BIT = 7;
  localparam int HI_DUPLEX_BIT = 6;
  localparam int HI_GP_LSB = 3;
  localparam int GP_WIDTH = 3;
  localparam int HI_STRAP_DRV_BIT = 5;

  // ----------------------------------------------------------------
  // Control synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int CTL_W = 6;
  localparam int CTL_CS = 0;
  localparam int CTL_CMD = 1;
  localparam int CTL_RD = 2;
  localparam int CTL_WR = 3;
  localparam int CTL_PROM_CLK = 4;
  localparam int CTL_PROM_SEL = 5;

  // ----------------------------------------------------------------
  // Function select of the link/activity pin in 16-bit mode
  // ----------------------------------------------------------------
  localparam logic [1:0] LNK_FUNC_LED = 2'h0;
  localparam logic [1:0] LNK_FUNC_IOWAIT = 2'h1;
  localparam logic [1:0] LNK_FUNC_WAKE = 2'h2;

  // ----------------------------------------------------------------
  // Start-up phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    HPSL_PH_FILL = 2'b00,
    HPSL_PH_WAIT = 2'b01,
    HPSL_PH_READY = 2'b10
  } hpsl_phase_t;

endpackage : hpsl_pkg

// file: core/hpsl_sync.sv
`timescale 1ns/1ns
module hpsl_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed
  {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] q;
  } hpsl_sync_t;

  hpsl_sync_t s_reg;
  hpsl_sync_t s_next;

  // ----------------------------------------------------------------
  // Three stages; a bit moves only once stages two and three agree
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.ff1 = async_in;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s_reg.ff2[i] == s_reg.ff3[i])
      begin
        s_next.q[i] = s_reg.ff3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.q;

endmodule : hpsl_sync

// file: core/hpsl_top.sv
// Overview of operation
// - Command line high means data port access, low means index port.
// - Read and write strobes active low, inverted by a PROM setting.
// - Chip select active low, invertible; strobes count only while selected.
// - Interrupt active high; clock strap or PROM setting inverts it.
// - Select strap high gives 8-bit bus, low gives 16-bit bus.
// - In 8-bit mode drive-type strap high makes interrupt open-drain.
// - Upper data pins carry data in 16-bit, alternate outputs in 8-bit.
// - Speed pin pulled low at 100M, floating at 10M.
// - Link pin: mode 1 link plus carrier, mode 0 carrier only.
// - Duplex pin: mode 1 low for full duplex, mode 0 low for 10M.
// - In 8-bit mode three general outputs follow register 1Fh.
// - In 8-bit mode the resume output asserts on a wake event.
// - Device usable 5 us after reset release; host waits that long.
// - In 16-bit mode speed pin may serve as IO16.
// - In 16-bit mode link pin may serve as IOWAIT or resume output.
`timescale 1ns/1ns
module hpsl_top
#(
  parameter int READY_CYCLES = hpsl_pkg::READY_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_select_n,
  input wire logic host_cmd,
  input wire logic host_read_strobe,
  input wire logic host_write_strobe,
  input wire logic [7:0] host_data_low_in,
  output logic [7:0] host_data_low_out,
  output logic [7:0] host_data_low_oe,
  input wire logic [7:0] host_data_high_in,
  output logic [7:0] host_data_high_out,
  output logic [7:0] host_data_high_oe,
  input wire logic serial_prom_clock,
  input wire logic serial_prom_select,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic speed_indicator_out,
  output logic speed_indicator_oe,
  output logic link_activity_indicator_out,
  output logic link_activity_indicator_oe,
  input wire logic cfg_read_invert,
  input wire logic cfg_write_invert,
  input wire logic cfg_select_invert,
  input wire logic cfg_irq_invert,
  input wire logic cfg_led_mode,
  input wire logic cfg_io16_enable,
  input wire logic [1:0] cfg_link_function,
  input wire logic irq_request,
  input wire logic phy_speed_100,
  input wire logic phy_link_up,
  input wire logic phy_carrier_sense,
  input wire logic phy_full_duplex,
  input wire logic iowait_request,
  input wire logic wake_event,
  input wire logic wake_clear,
  input wire logic [2:0] general_reg_value,
  input wire logic [15:0] read_data,
  output logic device_ready,
  output logic bus_is_8bit,
  output logic [7:0] index_value,
  output logic index_write_pulse,
  output logic data_write_pulse,
  output logic [15:0] data_write_value,
  output logic data_read_pulse,
  output logic remote_resume
);

  typedef struct packed
  {
    hpsl_pkg::hpsl_phase_t phase;
    logic [hpsl_pkg::CNT_W-1:0] cnt;
    logic width8;
    logic irq_low_strap;
    logic irq_od;
    logic rd_prev;
    logic wr_prev;
    logic [7:0] index;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic idx_wr;
    logic dat_wr;
    logic dat_rd;
    logic wake;
    logic [7:0] lo_oe;
    logic [7:0] hi_out;
    logic [7:0] hi_oe;
    logic spd_oe;
    logic lnk_out;
    logic lnk_oe;
    logic irq_out;
    logic irq_oe;
  } hpsl_state_t;

  hpsl_state_t s_reg;
  hpsl_state_t s_next;

  logic [hpsl_pkg::CTL_W-1:0] ctl_s;
  logic [15:0] data_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hpsl_active(input logic pin, input logic inv);
    return ~(pin ^ inv);
  endfunction : hpsl_active

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hpsl_sync #(.WIDTH(hpsl_pkg::CTL_W)) u_ctl_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({serial_prom_select, serial_prom_clock, host_write_strobe,
               host_read_strobe, host_cmd, host_select_n}),
    .sync_out(ctl_s)
  );

  hpsl_sync #(.WIDTH(16)) u_data_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({host_data_high_in, host_data_low_in}),
    .sync_out(data_s)
  );

  logic sel;
  logic rd_on;
  logic wr_on;
  logic cmd;
  logic ready;
  logic dpx_lit;
  logic lnk_lit;
  logic irq_lvl;

  assign cmd = ctl_s[hpsl_pkg::CTL_CMD];
  assign sel = hpsl_active(ctl_s[hpsl_pkg::CTL_CS], cfg_select_invert);
  assign rd_on = sel
    & hpsl_active(ctl_s[hpsl_pkg::CTL_RD], cfg_read_invert);
  assign wr_on = sel
    & hpsl_active(ctl_s[hpsl_pkg::CTL_WR], cfg_write_invert);
  assign ready = (s_reg.phase == hpsl_pkg::HPSL_PH_READY);
  assign dpx_lit = cfg_led_mode ? phy_full_duplex : ~phy_speed_100;
  // Activity blinks the lit link LED off, so both stay visible
  assign lnk_lit = cfg_led_mode ? (phy_link_up & ~phy_carrier_sense)
                                : phy_carrier_sense;
  assign irq_lvl = irq_request ^ s_reg.irq_low_strap ^ cfg_irq_invert;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.idx_wr = 1'b0;
    s_next.dat_wr = 1'b0;
    s_next.dat_rd = 1'b0;

    // Start-up: straps settle, then the ready delay runs out
    case (s_reg.phase)
      hpsl_pkg::HPSL_PH_FILL:
      begin
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == hpsl_pkg::CNT_W'(hpsl_pkg::SYNC_FILL))
        begin
          s_next.width8 = ctl_s[hpsl_pkg::CTL_PROM_SEL];
          s_next.irq_low_strap = ctl_s[hpsl_pkg::CTL_PROM_CLK];
          s_next.irq_od = ctl_s[hpsl_pkg::CTL_PROM_SEL]
            & data_s[8 + hpsl_pkg::HI_STRAP_DRV_BIT];
          s_next.phase = hpsl_pkg::HPSL_PH_WAIT;
        end
      end
      hpsl_pkg::HPSL_PH_WAIT:
      begin
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == hpsl_pkg::CNT_W'(READY_CYCLES - 1))
        begin
          s_next.phase = hpsl_pkg::HPSL_PH_READY;
        end
      end
      hpsl_pkg::HPSL_PH_READY:
      begin
        s_next.cnt = s_reg.cnt;
      end
      default:
      begin
        s_next.phase = hpsl_pkg::HPSL_PH_FILL;
      end
    endcase

    s_next.rd_prev = rd_on;
    s_next.wr_prev = wr_on;

    // Strobes before the ready point are dropped
    if (ready)
    begin
      if (rd_on && !s_reg.rd_prev)
      begin
        s_next.rdata = read_data;
        s_next.dat_rd = cmd;
      end
      // Write data is taken at the trailing edge, when it has settled
      if (!wr_on && s_reg.wr_prev)
      begin
        if (cmd)
        begin
          s_next.dat_wr = 1'b1;
          s_next.wdata = s_reg.width8 ? {8'h00, data_s[7:0]} : data_s;
        end
        else
        begin
          s_next.idx_wr = 1'b1;
          s_next.index = data_s[7:0];
        end
      end
    end

    // Set wins over clear
    s_next.wake = wake_event | (s_reg.wake & ~wake_clear);

    s_next.lo_oe = {8{ready & rd_on}};

    if (s_reg.width8 && s_reg.phase != hpsl_pkg::HPSL_PH_FILL)
    begin
      s_next.hi_out = 8'h00;
      s_next.hi_oe = 8'h00;
      s_next.hi_out[hpsl_pkg::HI_WAKE_BIT] = s_reg.wake;
      s_next.hi_oe[hpsl_pkg::HI_WAKE_BIT] = 1'b1;
      s_next.hi_oe[hpsl_pkg::HI_DUPLEX_BIT] = dpx_lit;
      s_next.hi_out[hpsl_pkg::HI_GP_LSB +: hpsl_pkg::GP_WIDTH] =
        general_reg_value;
      s_next.hi_oe[hpsl_pkg::HI_GP_LSB +: hpsl_pkg::GP_WIDTH] = 3'h7;
    end
    else if (!s_reg.width8)
    begin
      s_next.hi_out = s_next.rdata[15:8];
      s_next.hi_oe = {8{ready & rd_on}};
    end
    else
    begin
      // Left floating so the drive-type strap can still be read
      s_next.hi_out = 8'h00;
      s_next.hi_oe = 8'h00;
    end

    if (!s_reg.width8 && cfg_io16_enable)
    begin
      s_next.spd_oe = ready & sel;
    end
    else
    begin
      s_next.spd_oe = phy_speed_100;
    end

    s_next.lnk_out = 1'b0;
    s_next.lnk_oe = lnk_lit;
    if (!s_reg.width8)
    begin
      case (cfg_link_function)
        hpsl_pkg::LNK_FUNC_IOWAIT:
        begin
          s_next.lnk_oe = ready & sel & iowait_request;
        end
        hpsl_pkg::LNK_FUNC_WAKE:
        begin
          s_next.lnk_out = s_reg.wake;
          s_next.lnk_oe = 1'b1;
        end
        default:
        begin
          s_next.lnk_oe = lnk_lit;
        end
      endcase
    end

    // Open-drain pulls low only; the force type drives both levels
    s_next.irq_out = irq_lvl;
    s_next.irq_oe = (s_reg.phase != hpsl_pkg::HPSL_PH_FILL)
      & (~s_reg.irq_od | ~irq_lvl);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_data_low_out = s_reg.rdata[7:0];
  assign host_data_low_oe = s_reg.lo_oe;
  assign host_data_high_out = s_reg.hi_out;
  assign host_data_high_oe = s_reg.hi_oe;
  assign speed_indicator_out = 1'b0;
  assign speed_indicator_oe = s_reg.spd_oe;
  assign link_activity_indicator_out = s_reg.lnk_out;
  assign link_activity_indicator_oe = s_reg.lnk_oe;
  assign irq_pin_out = s_reg.irq_out;
  assign irq_pin_oe = s_reg.irq_oe;
  assign device_ready = ready;
  assign bus_is_8bit = s_reg.width8;
  assign index_value = s_reg.index;
  assign index_write_pulse = s_reg.idx_wr;
  assign data_write_pulse = s_reg.dat_wr;
  assign data_write_value = s_reg.wdata;
  assign data_read_pulse = s_reg.dat_rd;
  assign remote_resume = s_reg.wake;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [hpsl_pkg::CNT_W-1:0] since_rst;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      since_rst <= '0;
    end
    else if (since_rst != 8'hFF)
    begin
      since_rst <= since_rst + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_READY_DELAY: assert property (
    $rose(device_ready) |-> since_rst == hpsl_pkg::CNT_W'(READY_CYCLES))
    else $error("ready not reached at the set delay");
  AST_NO_EARLY_ACCESS: assert property (
    !$past(device_ready) |->
      !(index_write_pulse || data_write_pulse || data_read_pulse))
    else $error("access taken before ready");
  AST_DATA_PORT: assert property (
    (data_write_pulse || data_read_pulse) |-> $past(cmd))
    else $error("data port used with command line low");
  AST_INDEX_PORT: assert property (
    index_write_pulse |-> !$past(cmd) && index_value == $past(data_s[7:0]))
    else $error("index write wrong");
  AST_SELECTED: assert property (
    (index_write_pulse || data_write_pulse) |-> $past(wr_on, 2))
    else $error("write taken while not selected");
  AST_READ_POL: assert property (
    data_read_pulse |-> $past(rd_on) && !$past(rd_on, 2))
    else $error("read taken on wrong strobe level");
  AST_IRQ_POL: assert property (
    device_ready |=> irq_pin_out ==
      $past(irq_request ^ serial_prom_clock_cap() ^ cfg_irq_invert))
    else $error("interrupt polarity wrong");
  AST_STRAP_HOLD: assert property (
    device_ready |=> $stable(bus_is_8bit) && $stable(s_reg.irq_od))
    else $error("strap value changed after capture");
  AST_OD_NO_HIGH: assert property (
    (device_ready && s_reg.irq_od && irq_pin_oe) |-> !irq_pin_out)
    else $error("open-drain interrupt drove high");
  AST_SPEED: assert property (
    (device_ready && bus_is_8bit) |=> speed_indicator_oe == $past(phy_speed_100))
    else $error("speed indicator wrong");
  AST_GP: assert property (
    (device_ready && bus_is_8bit) |=>
      host_data_high_out[5:3] == $past(general_reg_value))
    else $error("general outputs do not follow register");
  AST_WAKE: assert property (
    wake_event |=> remote_resume [*2] or (remote_resume ##1 $past(wake_clear)))
    else $error("resume output missed a wake event");

  function automatic logic serial_prom_clock_cap();
    return s_reg.irq_low_strap;
  endfunction : serial_prom_clock_cap

  COV_INDEX_WRITE: cover property (index_write_pulse);
  COV_DATA_WRITE: cover property (data_write_pulse);
  COV_DATA_READ: cover property (data_read_pulse);
  COV_READY: cover property ($rose(device_ready));

endmodule : hpsl_top

// file: verif/hpsl_host_model.sv
`timescale 1ns/1ns
module hpsl_host_model
(
  input wire logic clk,
  input wire logic sel_inv,
  input wire logic rd_inv,
  input wire logic wr_inv,
  input wire logic [15:0] bus_in,
  output logic host_select_n,
  output logic host_cmd,
  output logic host_read_strobe,
  output logic host_write_strobe,
  output logic [15:0] data_out,
  output logic data_en
);
  // ----------------------------------------------------------------
  // Pin levels follow the configured polarity even while idle
  // ----------------------------------------------------------------
  logic sel_act = 1'b0;
  logic rd_act = 1'b0;
  logic wr_act = 1'b0;
  assign host_select_n = sel_act ~^ sel_inv;
  assign host_read_strobe = rd_act ~^ rd_inv;
  assign host_write_strobe = wr_act ~^ wr_inv;

  initial
  begin
    host_cmd = 1'b0;
    data_out = 16'h0000;
    data_en = 1'b0;
  end

  // ----------------------------------------------------------------
  // One command cycle; both phases well over the 4 clock minimum
  // ----------------------------------------------------------------
  task automatic access(input logic w, input logic s, input logic c,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #2;
    sel_act = s;
    host_cmd = c;
    data_out = d;
    data_en = w;
    @(posedge clk);
    #2;
    rd_act = ~w;
    wr_act = w;
    repeat (8) @(posedge clk);
    q = bus_in;
    #2;
    rd_act = 1'b0;
    wr_act = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    // Select returns to its idle level; command falls low and the data lines are released
    sel_act = 1'b0;
    host_cmd = 1'b0;
    data_en = 1'b0;
    repeat (6) @(posedge clk);
  endtask : access
endmodule : hpsl_host_model

// file: verif/test_host_port_strap_led_logic.sv
`timescale 1ns/1ns
module test_host_port_strap_led_logic;
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  localparam int RDY = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, cmd, rd_s, wr_s, hen, drv_pu, spclk, spsel, rdy, b8, resume;
  logic [7:0] lo_out, lo_oe, hi_out, hi_oe, idx;
  logic [15:0] hd, bus, dwv, q, rdat;
  logic irq_out, irq_oe, spd_out, spd_oe, lnk_out, lnk_oe, pi, pd, pr;
  logic rinv, winv, sinv, iinv, ledm, io16, irq_req, spd100, link, crs;
  logic fdx, iow, wev, wclr;
  logic [1:0] l2f;
  logic [2:0] gpr;
  int num_errors = 0;
  int compares = 0;
  int ni = 0, nd = 0, nr = 0, cyc = 0, rdy_t = 0;

  always #25 clk = ~clk;

  // Pins left alone by everyone sit at their pull-down, bit 13 may
  // carry the open-drain strap pull-up
  assign bus[7:0] = (lo_oe & lo_out) | (~lo_oe & {8{hen}} & hd[7:0]);
  assign bus[15:8] = (hi_oe & hi_out) | (~hi_oe & (({8{hen & ~b8}}
                     & hd[15:8]) | {2'b00, drv_pu, 5'b00000}));

  hpsl_host_model u_hpsl_host_model (.clk(clk), .sel_inv(sinv),
    .rd_inv(rinv), .wr_inv(winv), .bus_in(bus), .host_select_n(sel_n),
    .host_cmd(cmd), .host_read_strobe(rd_s), .host_write_strobe(wr_s),
    .data_out(hd), .data_en(hen));

  hpsl_top #(.READY_CYCLES(RDY)) u_hpsl_top (.clk(clk), .rst_n(rst_n),
    .host_select_n(sel_n), .host_cmd(cmd), .host_read_strobe(rd_s),
    .host_write_strobe(wr_s), .host_data_low_in(bus[7:0]),
    .host_data_low_out(lo_out), .host_data_low_oe(lo_oe),
    .host_data_high_in(bus[15:8]), .host_data_high_out(hi_out),
    .host_data_high_oe(hi_oe), .serial_prom_clock(spclk),
    .serial_prom_select(spsel), .irq_pin_out(irq_out),
    .irq_pin_oe(irq_oe), .speed_indicator_out(spd_out),
    .speed_indicator_oe(spd_oe), .link_activity_indicator_out(lnk_out),
    .link_activity_indicator_oe(lnk_oe), .cfg_read_invert(rinv),
    .cfg_write_invert(winv), .cfg_select_invert(sinv),
    .cfg_irq_invert(iinv), .cfg_led_mode(ledm), .cfg_io16_enable(io16),
    .cfg_link_function(l2f), .irq_request(irq_req),
    .phy_speed_100(spd100), .phy_link_up(link),
    .phy_carrier_sense(crs), .phy_full_duplex(fdx),
    .iowait_request(iow), .wake_event(wev), .wake_clear(wclr),
    .general_reg_value(gpr), .read_data(rdat), .device_ready(rdy),
    .bus_is_8bit(b8), .index_value(idx), .index_write_pulse(pi),
    .data_write_pulse(pd), .data_write_value(dwv),
    .data_read_pulse(pr), .remote_resume(resume));

  // ----------------------------------------------------------------
  // Pulse counters, ready delay and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    ni <= ni + int'(pi === 1'b1);
    nd <= nd + int'(pd === 1'b1);
    nr <= nr + int'(pr === 1'b1);
    rdy_t <= (!rst_n) ? 0 : rdy_t + int'(rdy !== 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // settle, acc and boot return 2 ns after a rising edge
  task automatic settle();
    repeat (3) @(posedge clk);
    #2;
  endtask : settle

  task automatic acc(input logic w, input logic s, input logic c,
                     input logic [15:0] d, input int ei, input int ed,
                     input int er);
    int a, b, e;
    a = ni;
    b = nd;
    e = nr;
    u_hpsl_host_model.access(w, s, c, d, q);
    repeat (4) @(posedge clk);
    #2;
    chk(16'(ni - a), 16'(ei), "index pulses");
    chk(16'(nd - b), 16'(ed), "data write pulses");
    chk(16'(nr - e), 16'(er), "data read pulses");
  endtask : acc

  task automatic boot(input logic s8, input logic ck, input logic g6);
    int n;
    spsel = s8;
    spclk = ck;
    drv_pu = g6;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    chk({lo_oe, hi_oe}, 16'h0000, "pins driven in reset");
    rst_n = 1'b1;
    acc(1'b1, 1'b1, 1'b0, 16'h00FF, 0, 0, 0);
    n = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(16'(rdy_t >= RDY && rdy_t <= RDY + 1), 16'h1, "ready delay");
  endtask : boot

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rinv, winv, sinv, iinv, ledm, io16, irq_req, spd100} = 8'h00;
    {link, crs, fdx, iow, wev, wclr, l2f, gpr} = 9'h000;
    {spsel, spclk, drv_pu} = 3'b000;
    rdat = 16'h0000;
    boot(1'b0, 1'b0, 1'b0);
    chk(b8, 16'h0, "bus width 16");
    acc(1'b1, 1'b1, 1'b0, 16'h005A, 1, 0, 0);
    chk(idx, 16'h5A, "index value");
    acc(1'b1, 1'b1, 1'b1, 16'hA5C3, 0, 1, 0);
    chk(dwv, 16'hA5C3, "16-bit write");
    rdat = 16'h1234;
    acc(1'b0, 1'b1, 1'b1, 16'h0000, 0, 0, 1);
    chk(q, 16'h1234, "16-bit read");
    acc(1'b1, 1'b0, 1'b0, 16'h00C3, 0, 0, 0);
    chk(idx, 16'h5A, "unselected write");
    {rinv, winv, sinv} = 3'b111;
    settle();
    settle();
    acc(1'b1, 1'b1, 1'b0, 16'h0033, 1, 0, 0);
    chk(idx, 16'h33, "inverted write");
    rdat = 16'hC00C;
    acc(1'b0, 1'b1, 1'b1, 16'h0000, 0, 0, 1);
    chk(q, 16'hC00C, "inverted read");
    {rinv, winv, sinv} = 3'b000;
    {io16, l2f, iow} = 4'b1011;
    settle();
    settle();
    fork
      acc(1'b0, 1'b1, 1'b1, 16'h0000, 0, 0, 1);
      begin
        repeat (7) @(posedge clk);
        #2;
        chk(spd_oe, 16'h1, "io16 while selected");
        chk(lnk_oe, 16'h1, "iowait while selected");
      end
    join
    chk(spd_oe, 16'h0, "io16 idle");
    {io16, l2f, iow} = 4'b0000;
    {spd100, crs} = 2'b11;
    settle();
    chk(spd_oe, 16'h1, "speed 100");
    chk(lnk_oe, 16'h1, "mode 0 carrier");
    {spd100, crs} = 2'b00;
    settle();
    chk(spd_oe, 16'h0, "speed 10");
    chk(lnk_oe, 16'h0, "mode 0 quiet");
    {ledm, link} = 2'b11;
    settle();
    chk(lnk_oe, 16'h1, "mode 1 link");
    crs = 1'b1;
    settle();
    chk(lnk_oe, 16'h0, "mode 1 activity");
    {ledm, link, crs, l2f} = 5'b00010;
    wev = 1'b1;
    @(posedge clk);
    #2;
    wev = 1'b0;
    settle();
    chk({lnk_oe, lnk_out, spd_out}, 16'h6, "link pin as resume");
    wclr = 1'b1;
    @(posedge clk);
    #2;
    wclr = 1'b0;
    settle();
    chk({lnk_oe, lnk_out}, 16'h2, "link resume cleared");
    l2f = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      {iinv, irq_req} = 2'(i);
      settle();
      chk({irq_oe, irq_out}, {15'h0001, i[1] ^ i[0]}, "irq level");
    end
    {iinv, irq_req, ledm, link, crs} = 5'h00;
    // Eight-bit straps, interrupt low active and open-drain
    boot(1'b1, 1'b1, 1'b1);
    chk(b8, 16'h1, "bus width 8");
    {spsel, spclk, drv_pu} = 3'b000;
    settle();
    chk(b8, 16'h1, "strap held");
    for (int i = 0; i < 2; i++)
    begin
      irq_req = i[0];
      settle();
      chk(irq_oe, 16'(i), "open drain enable");
      chk(irq_out & irq_oe, 16'h0, "open drain level");
    end
    acc(1'b1, 1'b1, 1'b1, 16'h00E7, 0, 1, 0);
    chk(dwv, 16'h00E7, "8-bit write");
    gpr = 3'b101;
    settle();
    chk({hi_oe[5:3], hi_out[5:3]}, 16'h3D, "general outputs");
    gpr = 3'b010;
    settle();
    chk({hi_oe[5:3], hi_out[5:3]}, 16'h3A, "general outputs");
    wev = 1'b1;
    @(posedge clk);
    #2;
    wev = 1'b0;
    settle();
    chk({resume, hi_oe[7], hi_out[7]}, 16'h7, "wake");
    wclr = 1'b1;
    @(posedge clk);
    #2;
    wclr = 1'b0;
    settle();
    chk(resume, 16'h0, "wake cleared");
    for (int i = 0; i < 4; i++)
    begin
      ledm = i[1];
      fdx = i[0];
      spd100 = i[0];
      settle();
      chk(hi_oe[6], {15'h0000, i[1] ~^ i[0]}, "duplex pin");
    end
    conclude();
  end
endmodule : test_host_port_strap_led_logic
